//--- fpm_mac_front_end.v
// Fixed-point multiply front end: input bank, two pipeline columns,
// pre-adders, constant bank, multipliers, 38-bit combiner, result FIFO.
// Assumes fabric drives all inputs synchronously to clk and wipes the
// datapath registers before the first operation.
`include "fpm_regs.vh"

// Result buffer; array read straight from the storage flops
module fpm_fifo #(
	parameter W = 8,
	parameter D = 4
) (
	input wire clk,
	input wire srst,
	input wire in_valid,
	output wire in_ready,
	input wire [W-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [W-1:0] out_data
);
	localparam AW = $clog2(D);
	reg [W-1:0] mem [0:D-1];
	reg [AW-1:0] wr_ptr_r;
	reg [AW-1:0] rd_ptr_r;
	reg [AW:0] count_r;
	wire push;
	wire pop;

	// Full and empty come from the count
	assign in_ready = (count_r != D[AW:0]);
	assign out_valid = (count_r != {(AW+1){1'b0}});
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	assign out_data = mem[rd_ptr_r];

	// Storage has no reset; only the pointers and the count matter
	always @(posedge clk)
	begin
		if (push)
			mem[wr_ptr_r] <= in_data;
	end

	// Pointer and count update
	always @(posedge clk)
	begin
		if (srst)
		begin
			wr_ptr_r <= {AW{1'b0}};
			rd_ptr_r <= {AW{1'b0}};
			count_r <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wr_ptr_r <= (wr_ptr_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
			if (pop)
				rd_ptr_r <= (rd_ptr_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
			if (push & ~pop)
				count_r <= count_r + 1'b1;
			else if (pop & ~push)
				count_r <= count_r - 1'b1;
		end
	end
endmodule // fpm_fifo

module fpm_mac_front_end (
	input wire clk,
	input wire srst,
	input wire fp_en,
	input wire [2:0] fx_mode,
	input wire [3:0] fp_mode,
	input wire x_unsigned,
	input wire in_valid,
	output wire in_ready,
	input wire [26:0] ax,
	input wire [26:0] ay,
	input wire [25:0] az,
	input wire [17:0] bx,
	input wire [18:0] by,
	input wire [17:0] bz,
	input wire [26:0] scan_in,
	output wire [26:0] scan_out,
	input wire dyn_accumulate,
	input wire preload_sel,
	input wire dyn_sub,
	input wire result_invert_sel,
	input wire scanin_sel,
	input wire chainout_mute,
	input wire [6:0] in_bypass,
	input wire pipe1_bypass,
	input wire pipe2_bypass,
	input wire [1:0] in_gate_sel,
	input wire [1:0] pipe1_gate_sel,
	input wire [1:0] pipe2_gate_sel,
	input wire [2:0] clock_gate_bits,
	input wire input_wipe,
	input wire pipe_output_wipe,
	input wire preadd_en,
	input wire preadd_sub,
	input wire coef_en,
	input wire [2:0] const_pick_upper,
	input wire [2:0] const_pick_lower,
	input wire coef_wr,
	input wire coef_wr_lower,
	input wire [2:0] coef_wr_idx,
	input wire [26:0] coef_wr_data,
	output wire out_valid,
	input wire out_ready,
	output wire [73:0] out_data,
	output wire out_accumulate,
	output wire out_preload,
	output wire out_invert,
	output wire [73:0] chain_out,
	output wire chain_in_en,
	output wire chain_out_en,
	output wire [2:0] slice_span
);
	// Mode decode
	reg [5:0] dyn_mask;
	reg fp_chain_in_ok;
	reg fp_acc_ok;
	wire m27 = (fx_mode == `FPM_FX_IND27);
	wire m9 = (fx_mode == `FPM_FX_M9X4);
	wire cplx = (fx_mode == `FPM_FX_CPLX18);
	wire plus36 = (fx_mode == `FPM_FX_PLUS36);
	// No pre-adder or constant bank in these modes
	wire pre_ok = preadd_en & ~m9 & ~plus36 & ~cplx;
	wire coef_ok = coef_en & ~m9 & ~plus36 & ~cplx;

	// Dynamic controls offered per fixed mode
	always @*
	begin
		case (fx_mode)
			`FPM_FX_M9X4: dyn_mask = `FPM_MSK_M9X4;
			`FPM_FX_IND18: dyn_mask = `FPM_MSK_IND18;
			`FPM_FX_IND27: dyn_mask = `FPM_MSK_IND27;
			`FPM_FX_SUM18: dyn_mask = `FPM_MSK_SUM18;
			`FPM_FX_SYST18: dyn_mask = `FPM_MSK_SYST18;
			`FPM_FX_PLUS36: dyn_mask = `FPM_MSK_PLUS36;
			`FPM_FX_CPLX18: dyn_mask = `FPM_MSK_NONE;
			default: dyn_mask = `FPM_MSK_NONE;
		endcase
	end

	// Float chain-in and accumulate availability
	always @*
	begin
		case (fp_mode)
			`FPM_FP_MADD32, `FPM_FP_VEC1_32, `FPM_FP_VEC2_32, `FPM_FP_SUM16ADD,
			`FPM_FP_VEC1_16, `FPM_FP_VEC2_16: fp_chain_in_ok = 1'b1;
			default: fp_chain_in_ok = 1'b0;
		endcase
		case (fp_mode)
			`FPM_FP_MACC32, `FPM_FP_SUM16ACC, `FPM_FP_VEC3_16: fp_acc_ok = 1'b1;
			default: fp_acc_ok = 1'b0;
		endcase
	end

	wire fp_cplx = (fp_mode == `FPM_FP_CPLX);
	// Chain ports per mode
	assign chain_in_en = fp_en ? fp_chain_in_ok : ~(m9 | plus36 | cplx | (fx_mode == `FPM_FX_IND18));
	assign chain_out_en = fp_en ? ~fp_cplx : ~(cplx | (fx_mode == `FPM_FX_IND18));
	assign slice_span = fp_en ? (fp_cplx ? `FPM_SPAN_FPCPLX : `FPM_SPAN_ONE) :
		(cplx ? `FPM_SPAN_CPLX18 : `FPM_SPAN_ONE);

	// Clock gate selection and stall
	wire fifo_ready;
	wire adv = fifo_ready; // Full buffer freezes every column
	wire g0 = clock_gate_bits[in_gate_sel];
	wire g1 = clock_gate_bits[pipe1_gate_sel];
	wire g2 = clock_gate_bits[pipe2_gate_sel];
	wire ld0 = adv & g0;
	wire ld1 = adv & g1;
	wire ld2 = adv & g2;
	wire bp0 = in_bypass[6];
	wire first_gate = ~bp0 ? g0 : (~pipe1_bypass ? g1 : (~pipe2_bypass ? g2 : 1'b1));
	wire last_gate = ~pipe2_bypass ? g2 : (~pipe1_bypass ? g1 : (~bp0 ? g0 : 1'b1));
	assign in_ready = adv & first_gate;

	// Scan input replaces the upper multiplier operand; 18 bits with pre-adder
	wire scan_raw = scanin_sel & dyn_mask[`FPM_DYN_SCAN];
	wire [26:0] scan_lim = pre_ok ? {{9{scan_in[`FPM_CASCADE_W-1]}}, scan_in[17:0]} : scan_in;
	wire [26:0] ay_in = scan_raw ? scan_lim : ay;
	wire [5:0] ctrl_in = {dyn_accumulate, preload_sel, dyn_sub, result_invert_sel, scanin_sel, chainout_mute};

	// Input register bank; data not reset, cleared by input wipe
	reg [26:0] ax_r, ay_r;
	reg [25:0] az_r;
	reg [17:0] bx_r, bz_r;
	reg [18:0] by_r;
	reg [5:0] ctrl0_r;
	reg v0_r;
	always @(posedge clk)
	begin
		if (input_wipe)
		begin
			ax_r <= 27'h000_0000;
			ay_r <= 27'h000_0000;
			az_r <= 26'h000_0000;
			bx_r <= 18'h0_0000;
			by_r <= 19'h0_0000;
			bz_r <= 18'h0_0000;
			ctrl0_r <= 6'h00;
		end
		else if (ld0)
		begin
			ax_r <= ax;
			ay_r <= ay_in;
			az_r <= az;
			bx_r <= bx;
			by_r <= by;
			bz_r <= bz;
			ctrl0_r <= ctrl_in;
		end
	end

	// Valid bits are control state and take srst
	always @(posedge clk)
	begin
		if (srst | input_wipe)
			v0_r <= 1'b0;
		else if (ld0)
			v0_r <= in_valid;
	end

	// Per-operand register or direct feed
	wire [26:0] ax_s = in_bypass[0] ? ax : ax_r;
	wire [26:0] ay_s = in_bypass[1] ? ay_in : ay_r;
	wire [25:0] az_s = in_bypass[2] ? az : az_r;
	wire [17:0] bx_s = in_bypass[3] ? bx : bx_r;
	wire [18:0] by_s = in_bypass[4] ? by : by_r;
	wire [17:0] bz_s = in_bypass[5] ? bz : bz_r;
	wire [5:0] ctrl0_s = bp0 ? ctrl_in : ctrl0_r;
	wire v0_s = bp0 ? in_valid : v0_r;
	assign scan_out = ay_s;

	// Pre-adders share one operation select
	wire ext = ~x_unsigned;
	wire [18:0] ya19 = {ext & ay_s[17], ay_s[17:0]};
	wire [18:0] za19 = {ext & az_s[17], az_s[17:0]};
	wire [18:0] yb19 = {ext & by_s[17], by_s[17:0]};
	wire [18:0] zb19 = {ext & bz_s[17], bz_s[17:0]};
	wire [18:0] pre_up19 = preadd_sub ? ya19 - za19 : ya19 + za19;
	wire [18:0] pre_lo19 = preadd_sub ? yb19 - zb19 : yb19 + zb19;
	wire [26:0] ya27 = {ay_s[25], ay_s[25:0]};
	wire [26:0] za27 = {az_s[25], az_s[25:0]};
	wire [26:0] pre_27 = preadd_sub ? ya27 - za27 : ya27 + za27;

	// Constant bank, eight entries per multiplier
	reg [26:0] coef_up [0:7];
	reg [17:0] coef_lo [0:7];
	always @(posedge clk)
	begin
		if (coef_wr & ~coef_wr_lower)
			coef_up[coef_wr_idx] <= coef_wr_data;
		if (coef_wr & coef_wr_lower)
			coef_lo[coef_wr_idx] <= coef_wr_data[17:0];
	end

	wire [26:0] x_up_c = coef_ok ? coef_up[const_pick_upper] : ax_s;
	wire [17:0] x_lo_c = coef_ok ? coef_lo[const_pick_lower] : bx_s;
	wire [26:0] y_up_c = m27 ? (pre_ok ? pre_27 : ay_s) :
		{8'h00, (pre_ok ? pre_up19 : ay_s[18:0])};
	wire [18:0] y_lo_c = pre_ok ? pre_lo19 : by_s;

	// First pipeline column
	reg [26:0] x_up_r, y_up_r;
	reg [17:0] x_lo_r;
	reg [18:0] y_lo_r;
	reg [5:0] ctrl1_r;
	reg v1_r;
	always @(posedge clk)
	begin
		if (pipe_output_wipe)
		begin
			x_up_r <= 27'h000_0000;
			y_up_r <= 27'h000_0000;
			x_lo_r <= 18'h0_0000;
			y_lo_r <= 19'h0_0000;
			ctrl1_r <= 6'h00;
		end
		else if (ld1)
		begin
			x_up_r <= x_up_c;
			y_up_r <= y_up_c;
			x_lo_r <= x_lo_c;
			y_lo_r <= y_lo_c;
			ctrl1_r <= ctrl0_s;
		end
	end

	always @(posedge clk)
	begin
		if (srst | pipe_output_wipe)
			v1_r <= 1'b0;
		else if (ld1)
			v1_r <= v0_s;
	end

	wire [26:0] x_up = pipe1_bypass ? x_up_c : x_up_r;
	wire [26:0] y_up = pipe1_bypass ? y_up_c : y_up_r;
	wire [17:0] x_lo = pipe1_bypass ? x_lo_c : x_lo_r;
	wire [18:0] y_lo = pipe1_bypass ? y_lo_c : y_lo_r;
	wire [5:0] ctrl1_s = pipe1_bypass ? ctrl0_s : ctrl1_r;
	wire v1_s = pipe1_bypass ? v0_s : v1_r;

	// Four 9x9 signed or 8x8 unsigned lanes
	wire [35:0] lx = {x_lo, x_up[17:0]};
	wire [35:0] ly = {y_lo[17:0], y_up[17:0]};
	wire [73:0] lane_ext [0:3];
	genvar i;
	generate
		for (i = 0; i < 4; i = i + 1)
		begin : g_lane
			wire [9:0] a = x_unsigned ? {2'h0, lx[9*i+7:9*i]} : {lx[9*i+8], lx[9*i+8:9*i]};
			wire [9:0] b = x_unsigned ? {2'h0, ly[9*i+7:9*i]} : {ly[9*i+8], ly[9*i+8:9*i]};
			wire [19:0] p = $signed(a) * $signed(b);
			assign lane_ext[i] = {{54{p[19]}}, p};
		end
	endgenerate

	// 18 x 19 pair and single 27 x 27
	wire [18:0] xu19 = {ext & x_up[17], x_up[17:0]};
	wire [18:0] xl19 = {ext & x_lo[17], x_lo};
	wire [37:0] prod_up = $signed(xu19) * $signed(y_up[18:0]);
	wire [37:0] prod_lo = $signed(xl19) * $signed(y_lo);
	wire [53:0] prod_27 = $signed(x_up) * $signed(y_up);
	wire [37:0] add36 = {{2{y_lo[17] & ext}}, y_lo[17:0], x_lo};

	// Combiner: minus select low adds, high subtracts; complex takes real part
	wire sub_eff = cplx | (ctrl1_s[`FPM_DYN_SUB] & dyn_mask[`FPM_DYN_SUB]);
	wire [37:0] rhs = plus36 ? add36 : prod_lo;
	wire [37:0] comb38 = sub_eff ? prod_up - rhs : prod_up + rhs;
	wire [73:0] sum4 = lane_ext[0] + lane_ext[1] + lane_ext[2] + lane_ext[3];
	reg [73:0] res_c;
	always @*
	begin
		case (fx_mode)
			`FPM_FX_M9X4: res_c = sum4;
			`FPM_FX_IND18: res_c = {prod_lo[36:0], prod_up[36:0]};
			`FPM_FX_IND27: res_c = {{20{prod_27[53]}}, prod_27};
			default: res_c = {{36{comb38[37]}}, comb38};
		endcase
	end

	// Effective controls to the accumulator side
	wire acc_c = fp_en ? (fp_acc_ok & ctrl1_s[`FPM_DYN_ACC]) : (dyn_mask[`FPM_DYN_ACC] & ctrl1_s[`FPM_DYN_ACC]);
	wire pre_c = ~fp_en & dyn_mask[`FPM_DYN_PRE] & ctrl1_s[`FPM_DYN_PRE];
	wire neg_c = ~fp_en & dyn_mask[`FPM_DYN_NEG] & ctrl1_s[`FPM_DYN_NEG];
	wire mute_c = dyn_mask[`FPM_DYN_MUTE] & ctrl1_s[`FPM_DYN_MUTE];

	// Second pipeline column
	reg [73:0] res_r;
	reg [3:0] ctrl2_r;
	reg v2_r;
	always @(posedge clk)
	begin
		if (pipe_output_wipe)
		begin
			res_r <= 74'h0;
			ctrl2_r <= 4'h0;
		end
		else if (ld2)
		begin
			res_r <= res_c;
			ctrl2_r <= {acc_c, pre_c, neg_c, mute_c};
		end
	end

	always @(posedge clk)
	begin
		if (srst | pipe_output_wipe)
			v2_r <= 1'b0;
		else if (ld2)
			v2_r <= v1_s;
	end

	wire [73:0] res_s = pipe2_bypass ? res_c : res_r;
	wire [3:0] ctrl2_s = pipe2_bypass ? {acc_c, pre_c, neg_c, mute_c} : ctrl2_r;
	wire v2_s = pipe2_bypass ? v1_s : v2_r;
	// Stalled gate would repeat a word, so push waits on the last gate
	wire push = v2_s & adv & last_gate;

	// Chain out holds the newest result; mute tracks the live control
	// so that raising it silences the output without a new word
	reg [73:0] chain_r;
	reg mute_r;
	always @(posedge clk)
	begin
		if (srst | pipe_output_wipe)
		begin
			chain_r <= 74'h0;
			mute_r <= 1'b1;
		end
		else
		begin
			if (push)
				chain_r <= res_s;
			if (adv & last_gate)
				mute_r <= ctrl2_s[0];
		end
	end
	assign chain_out = (mute_r | ~chain_out_en) ? 74'h0 : chain_r;

	wire [76:0] fifo_out;
	fpm_fifo #(
		.W(`FPM_WORD_W),
		.D(`FPM_FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.srst(srst),
		.in_valid(push),
		.in_ready(fifo_ready),
		.in_data({ctrl2_s[3:1], res_s}),
		.out_valid(out_valid),
		.out_ready(out_ready),
		.out_data(fifo_out)
	);
	assign out_data = fifo_out[73:0];
	assign out_invert = fifo_out[74];
	assign out_preload = fifo_out[75];
	assign out_accumulate = fifo_out[76];
endmodule // fpm_mac_front_end

//--- fpm_regs.vh
// Constants shared by the fixed-point multiply front end: mode codes,
// dynamic-control masks, widths and the result buffer depth.
// Assumes it is included by its bare name from the design file.
`ifndef FPM_REGS_VH
`define FPM_REGS_VH
// Fixed-point mode codes
`define FPM_FX_M9X4 3'h0
`define FPM_FX_IND18 3'h1
`define FPM_FX_IND27 3'h2
`define FPM_FX_SUM18 3'h3
`define FPM_FX_PLUS36 3'h4
`define FPM_FX_SYST18 3'h5
`define FPM_FX_CPLX18 3'h6
// Dynamic masks: [5] acc [4] preload [3] sub [2] invert [1] scan [0] chainout
`define FPM_DYN_ACC 5
`define FPM_DYN_PRE 4
`define FPM_DYN_SUB 3
`define FPM_DYN_NEG 2
`define FPM_DYN_SCAN 1
`define FPM_DYN_MUTE 0
`define FPM_MSK_M9X4 6'h31
`define FPM_MSK_IND18 6'h02
`define FPM_MSK_IND27 6'h35
`define FPM_MSK_SUM18 6'h3F
`define FPM_MSK_PLUS36 6'h3D
`define FPM_MSK_SYST18 6'h3F
`define FPM_MSK_NONE 6'h00
// Floating-point mode codes
`define FPM_FP_MUL32 4'h0
`define FPM_FP_ADD32 4'h1
`define FPM_FP_MADD32 4'h2
`define FPM_FP_MACC32 4'h3
`define FPM_FP_VEC1_32 4'h4
`define FPM_FP_VEC2_32 4'h5
`define FPM_FP_SUM16 4'h6
`define FPM_FP_SUM16ADD 4'h7
`define FPM_FP_SUM16ACC 4'h8
`define FPM_FP_VEC1_16 4'h9
`define FPM_FP_VEC2_16 4'hA
`define FPM_FP_VEC3_16 4'hB
`define FPM_FP_CPLX 4'hC
// Slice spans
`define FPM_SPAN_ONE 3'h1
`define FPM_SPAN_CPLX18 3'h2
`define FPM_SPAN_FPCPLX 3'h4
// Widths and buffer
`define FPM_RES_W 74
`define FPM_WORD_W 77
`define FPM_FIFO_DEPTH 32
`define FPM_CASCADE_W 18
`endif

//--- fpm_mac_front_end_chk.sv
// Concurrent checks for the multiply front end, watching its top ports.
// Assumes one clock, clk, and the synchronous reset srst.
module fpm_mac_front_end_chk (
	input wire logic clk,
	input wire logic srst,
	input wire logic fp_en,
	input wire logic [2:0] fx_mode,
	input wire logic [3:0] fp_mode,
	input wire logic in_valid,
	input wire logic in_ready,
	input wire logic [6:0] in_bypass,
	input wire logic pipe1_bypass,
	input wire logic pipe2_bypass,
	input wire logic chainout_mute,
	input wire logic out_valid,
	input wire logic out_ready,
	input wire logic [73:0] out_data,
	input wire logic [73:0] chain_out,
	input wire logic chain_in_en,
	input wire logic chain_out_en,
	input wire logic [2:0] slice_span
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	// Accepted word and the two extreme pipeline shapes
	wire take = in_valid & in_ready;
	wire all_byp = (in_bypass == 7'h7F) & pipe1_bypass & pipe2_bypass;
	wire no_byp = (in_bypass == 7'h00) & ~pipe1_bypass & ~pipe2_bypass;
	// Mode tables; flags are combinational, so no delay is allowed
	fixed_span_a: assert property (!fp_en |-> slice_span == ((fx_mode == 3'h6) ? 3'h2 : 3'h1))
		else $error("fixed mode slice span wrong");
	fx_chainin_a: assert property (!fp_en |-> chain_in_en == (fx_mode inside {3'h2, 3'h3, 3'h5}))
		else $error("fixed mode cascade input flag wrong");
	fpcplx_flags_a: assert property (fp_en && fp_mode == 4'hC |-> slice_span == 3'h4 && !chain_in_en && !chain_out_en)
		else $error("float complex flags wrong");
	fp_chainout_a: assert property (fp_en && fp_mode < 4'hC |-> chain_out_en && slice_span == 3'h1)
		else $error("float mode lost its chain output");
	fp_chainin_a: assert property (fp_en && fp_mode < 4'hC |->
		chain_in_en == (fp_mode inside {4'h2, 4'h4, 4'h5, 4'h7, 4'h9, 4'hA}))
		else $error("float cascade input flag wrong");
	// Chain output silenced by the mute control or by the mode
	mute_zero_a: assert property ((!fp_en && chainout_mute) [*5] |-> chain_out == 74'h0)
		else $error("muted chain output not zero");
	noce_zero_a: assert property (!chain_out_en |-> chain_out == 74'h0)
		else $error("disabled chain output not zero");
	// Head word stands while the fabric stalls
	head_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
		else $error("buffer head changed while stalled");
	// Latency follows the number of registered columns
	bypass_lat_a: assert property (take && all_byp |=> out_valid)
		else $error("bypassed word not presented next cycle");
	reg_lat_a: assert property (take && no_byp |-> ##4 out_valid)
		else $error("registered word not presented after four cycles");
	sum_mode_c: cover property (take && !fp_en && fx_mode == 3'h3);
	full_c: cover property (in_valid && !in_ready && out_valid);
	fp_cplx_c: cover property (fp_en && fp_mode == 4'hC && take);
endmodule // fpm_mac_front_end_chk

//--- fpm_fabric_model.sv
// Fabric side of the front end: wipes the datapath after reset or on
// request and throttles result acceptance. Shares clk and srst.
module fpm_fabric_model (
	input wire logic clk,
	input wire logic srst,
	input wire logic wipe_req,
	input wire logic [1:0] stall,
	output logic out_ready,
	output logic input_wipe,
	output logic pipe_output_wipe
);
	timeunit 1ns;
	timeprecision 1ns;
	logic srst_d_r = 1'b1;
	logic wipe_r = 1'b0;
	logic [1:0] ph_r = 2'h0;
	// Slice registers power up random, so wipe once before any work
	always @(posedge clk)
	begin
		srst_d_r <= srst;
		ph_r <= (srst || ph_r == 2'h2) ? 2'h0 : ph_r + 2'h1;
		wipe_r <= (srst_d_r & ~srst) | wipe_req;
	end
	assign input_wipe = wipe_r;
	assign pipe_output_wipe = wipe_r;
	// Stall 0 always ready, 1 never, 2 one cycle in three
	assign out_ready = (stall == 2'h0) | (stall == 2'h2 && ph_r == 2'h0);
endmodule // fpm_fabric_model

//--- fpm_mac_front_end_tb.sv
// Testbench for the multiply front end: tasks push operand words and pop
// results. Assumes the fabric model supplies wipes and out_ready.
module fpm_mac_front_end_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, srst, fp_en, x_unsigned, in_valid, in_ready, dyn_accumulate, preload_sel, dyn_sub;
	logic result_invert_sel, scanin_sel, chainout_mute, pipe1_bypass, pipe2_bypass, input_wipe;
	logic pipe_output_wipe, preadd_en, preadd_sub, coef_en, coef_wr, coef_wr_lower, wipe_req;
	logic out_valid, out_ready, out_accumulate, out_preload, out_invert, chain_in_en, chain_out_en;
	logic [2:0] fx_mode, clock_gate_bits, const_pick_upper, const_pick_lower, coef_wr_idx, slice_span, rf;
	logic [3:0] fp_mode;
	logic [26:0] ax, ay, scan_in, scan_out, coef_wr_data;
	logic [25:0] az;
	logic [17:0] bx, bz;
	logic [18:0] by;
	logic [6:0] in_bypass;
	logic [1:0] in_gate_sel, pipe1_gate_sel, pipe2_gate_sel, stall;
	logic [73:0] out_data, chain_out, r;
	logic [2:0] fxf [7] = '{3'h6, 3'h0, 3'h7, 3'h7, 3'h7, 3'h7, 3'h0};
	logic [73:0] q[$];
	logic [2:0] qf[$];
	int qc[$];
	int cyc = 0, t0 = 0, rc = 0, n = 0, miscompares = 0, samples_checked = 0;
	fpm_mac_front_end u_fpm_mac_front_end (.clk, .srst, .fp_en, .fx_mode, .fp_mode, .x_unsigned, .in_valid, .in_ready,
		.ax, .ay, .az, .bx, .by, .bz, .scan_in, .scan_out, .dyn_accumulate, .preload_sel, .dyn_sub, .result_invert_sel,
		.scanin_sel, .chainout_mute, .in_bypass, .pipe1_bypass, .pipe2_bypass, .in_gate_sel, .pipe1_gate_sel,
		.pipe2_gate_sel, .clock_gate_bits, .input_wipe, .pipe_output_wipe, .preadd_en, .preadd_sub, .coef_en,
		.const_pick_upper, .const_pick_lower, .coef_wr, .coef_wr_lower, .coef_wr_idx, .coef_wr_data, .out_valid,
		.out_ready, .out_data, .out_accumulate, .out_preload, .out_invert, .chain_out, .chain_in_en, .chain_out_en,
		.slice_span);
	fpm_fabric_model u_fpm_fabric_model (.clk, .srst, .wipe_req, .stall, .out_ready, .input_wipe, .pipe_output_wipe);
	// 25 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Record every popped word with its flags and cycle
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (out_valid === 1'b1 && out_ready === 1'b1)
		begin
			q.push_back(out_data);
			qf.push_back({out_accumulate, out_preload, out_invert});
			qc.push_back(cyc);
		end
	end
	task automatic chk(input string nm, input logic [73:0] got, input logic [73:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Hold the word until in_ready is seen high at a falling edge; the next rising edge takes it
	task automatic send(input logic [26:0] a, input logic [26:0] y);
		@(posedge clk);
		ax <= a;
		ay <= y;
		in_valid <= 1'b1;
		@(negedge clk);
		for (int k = 0; k < 50 && in_ready !== 1'b1; k++)
			@(negedge clk);
		@(posedge clk);
		t0 = cyc;
	endtask
	// Bounded wait for the next result; rc is cycles from take to pop
	task automatic get();
		in_valid <= 1'b0;
		repeat (60)
			if (q.size() == 0)
				@(posedge clk);
		r = (q.size() > 0) ? q.pop_front() : 'x;
		rf = (qf.size() > 0) ? qf.pop_front() : 'x;
		rc = (qc.size() > 0) ? qc.pop_front() - t0 : -1;
		@(posedge clk);
	endtask
	task automatic test_done();
		$display("samples_checked %0d miscompares %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		{fp_en, x_unsigned, in_valid, dyn_accumulate, preload_sel, dyn_sub, result_invert_sel, scanin_sel} = '0;
		{chainout_mute, pipe1_bypass, pipe2_bypass, preadd_en, preadd_sub, coef_en, coef_wr, coef_wr_lower} = '0;
		{wipe_req, fp_mode, ax, ay, scan_in, coef_wr_data, az, bx, bz, by, in_bypass, stall} = '0;
		{const_pick_upper, const_pick_lower, coef_wr_idx, in_gate_sel} = '0;
		srst = 1'b1;
		fx_mode = 3'h2;
		clock_gate_bits = 3'h7;
		pipe1_gate_sel = 2'h1;
		pipe2_gate_sel = 2'h2;
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		repeat (4) @(posedge clk);
		// Each registered column adds exactly one cycle
		for (int i = 0; i < 3; i++)
		begin
			{in_bypass, pipe1_bypass, pipe2_bypass} <= (i == 0) ? 9'h0 : (i == 1) ? 9'h1FF : 9'h2;
			send(27'd3, 27'd5);
			get();
			chk("product", r, 74'd15);
			chk("latency", rc, (i == 0) ? 4 : (i == 1) ? 1 : 3);
		end
		send(-27'sd3, 27'd1000);
		get();
		chk("signed product", r, -74'sd3000);
		// Equal operands, so either multiplicand may be the constant
		coef_wr_idx <= 3'h5;
		coef_wr_data <= 27'd9;
		coef_wr <= 1'b1;
		@(posedge clk);
		coef_wr <= 1'b0;
		coef_en <= 1'b1;
		const_pick_upper <= 3'h5;
		send(27'd11, 27'd11);
		get();
		chk("constant product", r, 74'd99);
		coef_en <= 1'b0;
		preadd_en <= 1'b1;
		az <= 26'd4;
		for (int i = 0; i < 2; i++)
		begin
			preadd_sub <= i[0];
			send(27'd6, 27'd6);
			get();
			chk("pre-added product", r, i ? 74'd12 : 74'd60);
		end
		preadd_en <= 1'b0;
		fx_mode <= 3'h3;
		bx <= 18'd3;
		by <= 19'd4;
		for (int i = 0; i < 2; i++)
		begin
			dyn_sub <= i[0];
			send(27'd5, 27'd7);
			get();
			chk("sum of products", r, i ? 74'd23 : 74'd47);
		end
		// Subtract stays raised: the independent pair must ignore it
		fx_mode <= 3'h1;
		by <= -19'sd4;
		send(-27'sd2, 27'd5);
		get();
		chk("paired products", r, {37'(-12), 37'(-10)});
		fx_mode <= 3'h3;
		by <= 19'd4;
		dyn_sub <= 1'b0;
		scanin_sel <= 1'b1;
		scan_in <= 27'd77;
		send(27'd5, 27'd7);
		get();
		chk("scan product", r, 74'd397);
		chk("scan out", 74'(scan_out), 74'd77);
		// A closed gate freezes the bank; a wipe clears it
		clock_gate_bits <= 3'h0;
		scanin_sel <= 1'b0;
		repeat (3) @(posedge clk);
		chk("frozen bank", 74'(scan_out), 74'd77);
		clock_gate_bits <= 3'h7;
		wipe_req <= 1'b1;
		@(posedge clk);
		wipe_req <= 1'b0;
		@(posedge clk);
		@(negedge clk);
		chk("wiped bank", 74'(scan_out), 74'h0);
		{dyn_accumulate, preload_sel, result_invert_sel} <= 3'h7;
		for (int m = 0; m < 7; m++)
		begin
			fx_mode <= m[2:0];
			send(27'd3, 27'd5);
			get();
			chk("fixed flags", rf, fxf[m]);
			chk("fixed chain", {chain_in_en, chain_out_en, slice_span},
				{(m inside {2, 3, 5}), (m inside {0, 2, 3, 4, 5}), (m == 6) ? 3'h2 : 3'h1});
		end
		fp_en <= 1'b1;
		for (int m = 0; m < 13; m++)
		begin
			fp_mode <= m[3:0];
			send(27'd3, 27'd5);
			get();
			chk("float acc", rf[2], (m inside {3, 8, 11}));
			chk("float chain", {chain_in_en, chain_out_en, slice_span},
				{(m inside {2, 4, 5, 7, 9, 10}), m != 12, (m == 12) ? 3'h4 : 3'h1});
		end
		{fp_en, dyn_accumulate, preload_sel, result_invert_sel} <= '0;
		fx_mode <= 3'h2;
		send(27'd3, 27'd5);
		get();
		chk("chain result", chain_out, 74'd15);
		chainout_mute <= 1'b1;
		repeat (4) @(posedge clk);
		chk("muted chain", chain_out, 74'h0);
		// Fill the buffer until it refuses, then drain it at a crawl
		{in_bypass, pipe1_bypass, pipe2_bypass} <= 9'h1FF;
		stall <= 2'h1;
		ax <= 27'd1;
		in_valid <= 1'b1;
		n = 0;
		repeat (40)
		begin
			ay <= 27'(n);
			@(negedge clk);
			if (in_ready === 1'b1)
				n++;
			@(posedge clk);
		end
		chk("accepted words", n, 74'd32);
		stall <= 2'h2;
		for (int i = 0; i < 32; i++)
		begin
			get();
			chk("drained word", r, 74'(i));
		end
		test_done();
	end
	// Hang guard
	initial
	begin
		#(40 * 6000);
		miscompares++;
		test_done();
	end
endmodule // fpm_mac_front_end_tb
bind fpm_mac_front_end fpm_mac_front_end_chk u_fpm_mac_front_end_chk (.clk, .srst, .fp_en, .fx_mode, .fp_mode,
	.in_valid, .in_ready, .in_bypass, .pipe1_bypass, .pipe2_bypass, .chainout_mute, .out_valid, .out_ready,
	.out_data, .chain_out, .chain_in_en, .chain_out_en, .slice_span);
